/* common/splc_cfg.svh */
// constants of the sector protect and lock control block
//
// What this block does
// - status write bits 5..2: 0000 unprotects all, 1111 protects all, else nothing
// - lock clear: writing 00h unprotects all sectors, lock stays zero
// - lock clear: writing 7Fh protects all sectors, lock stays zero
// - lock clear: writing FFh protects all sectors and sets lock
// - pin high, lock set: writing 0Fh clears lock, protection unchanged
// - lock clear: writing F0h sets lock, protection unchanged
// - bits 5..2 are decoded only; bit 7 lock is the only stored bit
// - status read shows pin level and protection summary in bits 4..2
// - pin low and lock set: status writes change neither lock nor protection, only clear write enable
// - pin high and lock set: no global op, written bit 7 zero clears lock
// - protection read is opcode 3Ch and three address bytes in a sector
// - after the address, output repeats FFh if protected, 00h if not
// - chip select high ends the read anywhere and floats serial output
// - protection read returns only the sector bit, never the pin level
// - status shows whether all, some or none of the sectors are protected
// - one bit per 64 KB sector, all set at power-up
// - global protect during suspend aborts, no change, clears write enable
// - hardware lock only with pin low and lock set
`ifndef SPLC_CFG_SVH
`define SPLC_CFG_SVH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define SPLC_SECTORS      64
`define SPLC_SECT_W       6
`define SPLC_CNT_W        8
`define SPLC_CNT_MAX      8'hff

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define SPLC_OP_WR_STAT1  8'h01
`define SPLC_OP_RD_STAT   8'h05
`define SPLC_OP_WR_EN     8'h06
`define SPLC_OP_WR_DIS    8'h04
`define SPLC_OP_RD_PROT   8'h3c

// ----------------------------------------------------------------
// bit counts at which phases end
// ----------------------------------------------------------------
`define SPLC_OPC_LAST     8'h07
`define SPLC_BYTE1_LAST   8'h0f
`define SPLC_OPC_BITS     8'h08
`define SPLC_WSR_BITS     8'h10
`define SPLC_ADDR_LAST    8'h1f
`define SPLC_ADDR_BITS    8'h20

// ----------------------------------------------------------------
// status byte fields and decode patterns
// ----------------------------------------------------------------
`define SPLC_LOCK_POS     7
`define SPLC_GLOB_HI      5
`define SPLC_GLOB_LO      2
`define SPLC_GLOB_NONE    4'h0
`define SPLC_GLOB_ALL     4'hf
`define SPLC_SWP_NONE     2'h0
`define SPLC_SWP_SOME     2'h1
`define SPLC_SWP_ALL      2'h3
`define SPLC_PROT_RST     1'b1
`define SPLC_LOCK_RST     1'b0

`endif

/* common/splc_pkg.sv */
// types of the sector protect and lock control block
package splc_pkg;

  // ----------------------------------------------------------------
  // status byte as read by the host
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       lock;
    logic       rsvd6;
    logic       rsvd5;
    logic       wp_level;
    logic [1:0] software_protect_summary;
    logic       write_enable_latch;
    logic       busy;
  } splc_status_s;

  // ----------------------------------------------------------------
  // synchronised serial pins
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
  } splc_pins_s;

  // ----------------------------------------------------------------
  // output phase of the current frame
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SPLC_OUT_IDLE = 2'b00,
    SPLC_OUT_STAT = 2'b01,
    SPLC_OUT_PROT = 2'b10
  } splc_out_e;

endpackage

/* design/splc_top.sv */
// serial protection and lock control of the flash
`timescale 1ns/1ps
`include "splc_cfg.svh"

module splc_top
  import splc_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic       CS_N,
  input  wire logic       SCK,
  input  wire logic       SI,
  input  wire logic       WP_N,
  input  wire logic       SUSPEND_ACTIVE,
  output      logic       SO,
  output      logic       SO_OE,
  output      logic       LOCK_BIT,
  output      logic       WRITE_ENABLE_LATCH,
  output      logic [1:0] SOFTWARE_PROTECT_SUMMARY,
  output      logic       HW_LOCKED
);

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  splc_pins_s pin_s1_q;
  splc_pins_s pin_s2_q;
  logic       sck_d1_q;
  logic       cs_d1_q;
  logic       susp_s1_q;
  logic       susp_s2_q;

  // two flops per pin, then one more for edges
  always_ff @(posedge CLK) begin
    pin_s1_q  <= '{cs_n: CS_N, sck: SCK, si: SI, wp_n: WP_N};
    pin_s2_q  <= pin_s1_q;
    susp_s1_q <= SUSPEND_ACTIVE;
    susp_s2_q <= susp_s1_q;
    if (!RST_N) begin
      sck_d1_q <= 1'b0;
      cs_d1_q  <= 1'b1;
    end else begin
      sck_d1_q <= pin_s2_q.sck;
      cs_d1_q  <= pin_s2_q.cs_n;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic cs_act;
  logic cs_end;

  assign cs_act   = !pin_s2_q.cs_n;
  assign sck_rise = cs_act && pin_s2_q.sck && !sck_d1_q;
  assign sck_fall = cs_act && !pin_s2_q.sck && sck_d1_q;
  assign cs_end   = pin_s2_q.cs_n && !cs_d1_q;

  // ----------------------------------------------------------------
  // protection state and serial engine
  // ----------------------------------------------------------------
  logic [`SPLC_SECTORS-1:0] prot_q, prot_d;
  logic                     lock_q, lock_d;
  logic                     wel_q, wel_d;
  logic [`SPLC_CNT_W-1:0]   cnt_q, cnt_d;
  logic [7:0]               in_q, in_d;
  logic [7:0]               opc_q, opc_d;
  logic [7:0]               data_q, data_d;
  logic [`SPLC_SECT_W-1:0]  sect_q, sect_d;
  logic [7:0]               out_q, out_d;
  splc_out_e                phase_q, phase_d;
  logic                     so_q, so_d;
  logic                     oe_q, oe_d;
  logic [1:0]               swp_q, swp_d;
  logic                     hwl_q, hwl_d;

  logic [7:0]   shifted;
  logic [3:0]   glob;
  logic         aligned;
  splc_status_s stat;

  assign shifted = {in_q[6:0], pin_s2_q.si};
  assign glob    = data_q[`SPLC_GLOB_HI:`SPLC_GLOB_LO];
  assign aligned = (cnt_q[2:0] == 3'h0);

  // status byte: bits 4..2 reflect pin and summary, not written data
  always_comb begin
    stat          = '0;
    stat.lock     = lock_q;
    stat.wp_level = pin_s2_q.wp_n;
    stat.software_protect_summary      = swp_q;
    stat.write_enable_latch      = wel_q;
  end

  // next state of the serial engine and protection bits
  always_comb begin
    prot_d  = prot_q;
    lock_d  = lock_q;
    wel_d   = wel_q;
    cnt_d   = cnt_q;
    in_d    = in_q;
    opc_d   = opc_q;
    data_d  = data_q;
    sect_d  = sect_q;
    out_d   = out_q;
    phase_d = phase_q;
    so_d    = so_q;
    oe_d    = oe_q;
    // sample input bits on rising clock edges
    if (sck_rise) begin
      in_d = shifted;
      if (cnt_q != `SPLC_CNT_MAX)
        cnt_d = cnt_q + 8'h01;
      if (cnt_q == `SPLC_OPC_LAST) begin
        opc_d = shifted;
        if (shifted == `SPLC_OP_RD_STAT) begin
          phase_d = SPLC_OUT_STAT;
          out_d   = stat;
        end
      end
      if (cnt_q == `SPLC_BYTE1_LAST) begin
        data_d = shifted;
        sect_d = shifted[`SPLC_SECT_W-1:0];
      end
      if (cnt_q == `SPLC_ADDR_LAST && opc_q == `SPLC_OP_RD_PROT) begin
        phase_d = SPLC_OUT_PROT;
        out_d   = {8{prot_q[sect_q]}};
      end
    end
    // drive output on falling edges, byte repeats by rotation
    if (sck_fall && phase_q != SPLC_OUT_IDLE) begin
      so_d  = out_q[7];
      oe_d  = 1'b1;
      out_d = {out_q[6:0], out_q[7]};
    end
    // chip select high ends any frame at any bit
    if (cs_end) begin
      phase_d = SPLC_OUT_IDLE;
      oe_d    = 1'b0;
      so_d    = 1'b0;
      cnt_d   = '0;
      if (aligned && cnt_q >= `SPLC_OPC_BITS) begin
        if (opc_q == `SPLC_OP_WR_EN)
          wel_d = 1'b1;
        if (opc_q == `SPLC_OP_WR_DIS)
          wel_d = 1'b0;
      end
      if (opc_q == `SPLC_OP_WR_STAT1 && cnt_q >= `SPLC_OPC_BITS) begin
        wel_d = 1'b0;
        if (wel_q && aligned && cnt_q >= `SPLC_WSR_BITS) begin
          if (!pin_s2_q.wp_n && lock_q) begin
            lock_d = lock_q;
          end else if (lock_q) begin
            lock_d = data_q[`SPLC_LOCK_POS];
          end else if (glob == `SPLC_GLOB_ALL && susp_s2_q) begin
            lock_d = lock_q;
          end else begin
            lock_d = data_q[`SPLC_LOCK_POS];
            if (glob == `SPLC_GLOB_NONE)
              prot_d = '0;
            else if (glob == `SPLC_GLOB_ALL)
              prot_d = '1;
          end
        end
      end
      opc_d = '0;
    end
  end

  // summary of protection and hardware lock state
  always_comb begin
    if (&prot_q)
      swp_d = `SPLC_SWP_ALL;
    else if (|prot_q)
      swp_d = `SPLC_SWP_SOME;
    else
      swp_d = `SPLC_SWP_NONE;
    hwl_d = !pin_s2_q.wp_n && lock_q;
  end

  // registers of the engine
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      prot_q  <= {`SPLC_SECTORS{`SPLC_PROT_RST}};
      lock_q  <= `SPLC_LOCK_RST;
      wel_q   <= 1'b0;
      cnt_q   <= '0;
      in_q    <= '0;
      opc_q   <= '0;
      data_q  <= '0;
      sect_q  <= '0;
      out_q   <= '0;
      phase_q <= SPLC_OUT_IDLE;
      so_q    <= 1'b0;
      oe_q    <= 1'b0;
      swp_q   <= `SPLC_SWP_ALL;
      hwl_q   <= 1'b0;
    end else begin
      prot_q  <= prot_d;
      lock_q  <= lock_d;
      wel_q   <= wel_d;
      cnt_q   <= cnt_d;
      in_q    <= in_d;
      opc_q   <= opc_d;
      data_q  <= data_d;
      sect_q  <= sect_d;
      out_q   <= out_d;
      phase_q <= phase_d;
      so_q    <= so_d;
      oe_q    <= oe_d;
      swp_q   <= swp_d;
      hwl_q   <= hwl_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------
  assign SO                       = so_q;
  assign SO_OE                    = oe_q;
  assign LOCK_BIT                 = lock_q;
  assign WRITE_ENABLE_LATCH       = wel_q;
  assign SOFTWARE_PROTECT_SUMMARY = swp_q;
  assign HW_LOCKED                = hwl_q;

endmodule

/* bench/splc_properties.sv */
// port checker of the sector protect and lock control block
`timescale 1ns/1ps
module splc_properties (
  input logic       CLK,
  input logic       RST_N,
  input logic       CS_N,
  input logic       SCK,
  input logic       SI,
  input logic       WP_N,
  input logic       SUSPEND_ACTIVE,
  input logic       SO,
  input logic       SO_OE,
  input logic       LOCK_BIT,
  input logic       WRITE_ENABLE_LATCH,
  input logic [1:0] SOFTWARE_PROTECT_SUMMARY,
  input logic       HW_LOCKED
);
  // all checks on the system clock, off in reset
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_hw_needs_lock: assert property (HW_LOCKED |-> LOCK_BIT)
    else $error("hardware lock without lock bit");
  a_hw_freeze: assert property (
    HW_LOCKED && $past(HW_LOCKED) |->
    $stable(LOCK_BIT) && $stable(SOFTWARE_PROTECT_SUMMARY))
    else $error("state moved while hardware locked");
  a_idle_float: assert property (CS_N [*8] |-> !SO_OE)
    else $error("serial output driven while deselected");
  a_oe_in_frame: assert property ($rose(SO_OE) |-> !CS_N)
    else $error("output enabled outside a frame");
  a_swp_codes: assert property (SOFTWARE_PROTECT_SUMMARY != 2'h2)
    else $error("illegal protection summary");
  a_wel_at_end: assert property (
    $changed(WRITE_ENABLE_LATCH) |-> CS_N)
    else $error("write enable moved inside a frame");
  a_lock_at_end: assert property ($changed(LOCK_BIT) |-> CS_N)
    else $error("lock bit moved inside a frame");
  a_lock_needs_wel: assert property (
    $changed(LOCK_BIT) |-> $past(WRITE_ENABLE_LATCH))
    else $error("lock bit moved without write enable");
  a_prot_needs_wel: assert property (
    $changed(SOFTWARE_PROTECT_SUMMARY)
    |-> CS_N && $past(WRITE_ENABLE_LATCH, 2))
    else $error("protection moved without a status write");

  // main scenarios reached
  c_hw_lock: cover property ($rose(HW_LOCKED));
  c_out_on: cover property ($rose(SO_OE));
  c_unprot: cover property ($fell(SOFTWARE_PROTECT_SUMMARY[1]));
endmodule

bind splc_top splc_properties u_props (.CLK, .RST_N, .CS_N, .SCK, .SI,
  .WP_N, .SUSPEND_ACTIVE, .SO, .SO_OE, .LOCK_BIT, .WRITE_ENABLE_LATCH,
  .SOFTWARE_PROTECT_SUMMARY, .HW_LOCKED);

/* bench/splc_host.sv */
// spi host model that clocks frames into the block
`timescale 1ns/1ps
module splc_host (
  input  logic CLK,
  input  logic SO,
  output logic CS_N,
  output logic SCK,
  output logic SI
);
  // idle pins: deselected, clock parked low
  initial begin
    CS_N = 1'b1;
    SCK  = 1'b0;
    SI   = 1'b0;
  end

  // one mode 0 frame of n bits, msb first; keeps last 16 output bits
  task automatic xfer(input logic [63:0] d, input int n,
                      output logic [15:0] rx);
    rx = 16'h0000;
    CS_N <= 1'b0;
    repeat (4) @(posedge CLK);
    for (int i = n - 1; i >= 0; i--) begin
      SI <= d[i];
      repeat (4) @(posedge CLK);
      SCK <= 1'b1;
      repeat (4) @(posedge CLK);
      rx = {rx[14:0], SO}; // sampled late in the high phase
      SCK <= 1'b0;
    end
    repeat (4) @(posedge CLK);
    CS_N <= 1'b1;
    SI   <= ~SI; // released line shows no stale level
    repeat (8) @(posedge CLK);
  endtask
endmodule

/* bench/splc_top_bench.sv */
// self-checking bench of the sector protect and lock control block
`timescale 1ns/1ps
module splc_top_bench;
  import splc_pkg::*;
  logic clk, rst_n, wp_n, susp, cs_n, sck, si, so, so_oe;
  logic lock, write_enable_latch, hwl;
  logic [1:0] software_protect_summary;
  logic [15:0] rx;
  int error_cnt, n_checks;

  splc_top u_dut (.CLK(clk), .RST_N(rst_n), .CS_N(cs_n), .SCK(sck),
    .SI(si), .WP_N(wp_n), .SUSPEND_ACTIVE(susp), .SO(so), .SO_OE(so_oe),
    .LOCK_BIT(lock), .WRITE_ENABLE_LATCH(write_enable_latch),
    .SOFTWARE_PROTECT_SUMMARY(software_protect_summary), .HW_LOCKED(hwl));
  splc_host u_host (.CLK(clk), .SO(so), .CS_N(cs_n), .SCK(sck), .SI(si));

  // compare one value and count it
  task automatic chk(input string what, input logic [15:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask

  // print counts and the verdict, then stop
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // write enable, one status write, then judge lock, summary, latch
  task automatic wstat(input logic wp, su, input logic [7:0] b,
                       input logic lk, input logic [1:0] sm);
    wp_n <= wp;
    susp <= su;
    u_host.xfer(64'h06, 8, rx);
    chk("wel set", 16'h1, 16'(write_enable_latch));
    u_host.xfer(64'({8'h01, b}), 16, rx);
    chk("lock", 16'(lk), 16'(lock));
    chk("summary", 16'(sm), 16'(software_protect_summary));
    chk("wel clear", 16'h0, 16'(write_enable_latch));
    chk("hw lock", 16'(!wp && lk), 16'(hwl));
    susp <= 1'b0;
  endtask

  // write enable, then write disable clears the latch again
  task automatic wdis;
    u_host.xfer(64'h06, 8, rx);
    chk("wel on", 16'h1, 16'(write_enable_latch));
    u_host.xfer(64'h04, 8, rx);
    chk("wel off", 16'h0, 16'(write_enable_latch));
  endtask

  // sector read, whole bytes then a cut mid byte
  task automatic prot_rd(input logic [23:0] a, input logic [15:0] e);
    u_host.xfer(64'({8'h3c, a, 16'h0000}), 48, rx);
    chk("prot bytes", e, rx);
    u_host.xfer(64'({8'h3c, a, 13'h0000}), 45, rx);
    chk("prot cut", {3'h0, e[12:0]}, {3'h0, rx[12:0]});
    chk("so float", 16'h0, 16'(so_oe));
  endtask

  // status byte read with the pin at a given level
  task automatic stat_rd(input logic wp, input logic [7:0] e);
    wp_n <= wp;
    u_host.xfer(64'h0500, 16, rx);
    chk("status", 16'(e), {8'h00, rx[7:0]});
  endtask

  // free-running system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // watchdog on the whole run
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    wp_n  = 1'b1;
    susp  = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("lock rst", 16'h0, 16'(lock));
    chk("swp rst", 16'h3, 16'(software_protect_summary));
    prot_rd(24'h3fabcd, 16'hffff);
    wdis();
    wstat(1'b1, 1'b0, 8'h00, 1'b0, 2'h0);
    prot_rd(24'h000000, 16'h0000);
    wstat(1'b1, 1'b0, 8'h14, 1'b0, 2'h0);
    wstat(1'b1, 1'b0, 8'h7f, 1'b0, 2'h3);
    stat_rd(1'b1, 8'h1c);
    wstat(1'b1, 1'b0, 8'hff, 1'b1, 2'h3);
    wstat(1'b1, 1'b0, 8'h00, 1'b0, 2'h3);
    wstat(1'b1, 1'b0, 8'hf0, 1'b1, 2'h3);
    wstat(1'b1, 1'b0, 8'h0f, 1'b0, 2'h3);
    wstat(1'b1, 1'b0, 8'hc3, 1'b1, 2'h0);
    wstat(1'b0, 1'b0, 8'h7f, 1'b1, 2'h0);
    stat_rd(1'b0, 8'h80);
    wstat(1'b1, 1'b0, 8'h0f, 1'b0, 2'h0);
    wstat(1'b1, 1'b1, 8'h7f, 1'b0, 2'h0);
    wstat(1'b1, 1'b0, 8'h7f, 1'b0, 2'h3);
    prot_rd(24'h3fabcd, 16'hffff);
    give_verdict();
  end
endmodule
